// ### rtl/async_serial_transmitter.sv
// Top of the asynchronous serial transmitter: APB registers, holding buffer,
// buffer-empty flag and transfer control. Assumes APB master keeps the protocol.
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps

module async_serial_transmitter
    import async_tx_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Power state
    input wire logic sleep_i,
    // Serial line
    output logic tx_o,
    output logic tx_oe_o
);
    import async_tx_pkg::*;

    if (ADDR_W < 5) begin : g_chk
        $error("async_serial_transmitter: ADDR_W too small for the map");
    end

    shift_if sif ();

    ////////////////////////////////////////////////////////////////////////////
    // Software-visible state
    logic ninth_data_bit_r, ninth_data_bit_nxt;
    logic sync_select_r, sync_select_nxt;
    logic tx_enable_bit_r, tx_enable_bit_nxt;
    logic nine_bit_select_r, nine_bit_select_nxt;
    logic serial_port_enable_r, serial_port_enable_nxt;
    logic tx_irq_enable_r, tx_irq_enable_nxt;
    logic [7:0] baud_divisor_r, baud_divisor_nxt;
    logic [7:0] tx_holding_buffer_r, tx_holding_buffer_nxt;
    logic tx_buffer_empty_flag_r, tx_buffer_empty_flag_nxt;

    // Bus state
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic tx_oe_r, tx_oe_nxt;

    logic [7:0] offset;
    logic setup_ph;
    logic wr_commit;
    logic wr_lane0;
    logic wr_holding;
    logic mapped;
    logic tx_run;
    logic cyc_en;
    logic bit_tick;
    logic xfer;

    function automatic logic is_mapped(input logic [7:0] ofs);
        return ofs == OFS_TX_STATUS_CONTROL || ofs == OFS_TX_HOLDING || ofs == OFS_BAUD_DIVISOR ||
            ofs == OFS_PERIPH_FLAG || ofs == OFS_PERIPH_ENABLE || ofs == OFS_PORT_CONTROL;
    endfunction : is_mapped

    assign offset = 8'(paddr_i);
    assign mapped = is_mapped(offset);
    assign setup_ph = psel_i && !penable_i;
    assign wr_commit = psel_i && penable_i && pready_r && pwrite_i && !pslverr_r;
    assign wr_lane0 = wr_commit && pstrb_i[0];
    assign wr_holding = wr_lane0 && offset == OFS_TX_HOLDING;

    // Abort on losing either enable; synchronous mode keeps it idle too
    assign tx_run = serial_port_enable_r && tx_enable_bit_r && !sync_select_r; // [RULE6] [RULE17]

    // Move only when the shifter is idle, one instruction cycle per move.
    // A move never shares a cycle with a buffer write, so the flag never sees both.
    assign xfer = tx_run && !sleep_i && !tx_buffer_empty_flag_r && sif.empty && cyc_en && !wr_holding; // [RULE7] [RULE8] [RULE13]

    ////////////////////////////////////////////////////////////////////////////
    // Register writes and flag
    always_comb begin
        ninth_data_bit_nxt = ninth_data_bit_r;
        sync_select_nxt = sync_select_r;
        tx_enable_bit_nxt = tx_enable_bit_r;
        nine_bit_select_nxt = nine_bit_select_r;
        serial_port_enable_nxt = serial_port_enable_r;
        tx_irq_enable_nxt = tx_irq_enable_r;
        baud_divisor_nxt = baud_divisor_r;
        tx_holding_buffer_nxt = tx_holding_buffer_r;
        tx_buffer_empty_flag_nxt = tx_buffer_empty_flag_r;
        if (wr_lane0) begin
            case (offset)
                OFS_TX_STATUS_CONTROL: begin
                    // Shifter-empty bit is status only; writes to it are dropped [RULE10]
                    ninth_data_bit_nxt = pwdata_i[BIT_NINTH_DATA];
                    sync_select_nxt = pwdata_i[BIT_SYNC_SELECT];
                    tx_enable_bit_nxt = pwdata_i[BIT_TX_ENABLE];
                    nine_bit_select_nxt = pwdata_i[BIT_NINE_SELECT];
                end
                OFS_TX_HOLDING: tx_holding_buffer_nxt = pwdata_i[7:0];
                OFS_BAUD_DIVISOR: baud_divisor_nxt = pwdata_i[7:0];
                OFS_PERIPH_ENABLE: tx_irq_enable_nxt = pwdata_i[BIT_IRQ_ENABLE];
                OFS_PORT_CONTROL: serial_port_enable_nxt = pwdata_i[BIT_PORT_ENABLE];
                // Flag register ignores writes [RULE9]
                default: ;
            endcase
        end
        if (wr_holding) begin
            tx_buffer_empty_flag_nxt = 1'b0; // [RULE9]
        end else if (xfer) begin
            tx_buffer_empty_flag_nxt = 1'b1; // [RULE8] [RULE9]
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ninth_data_bit_r <= RST_CTRL_BIT;
            sync_select_r <= RST_CTRL_BIT;
            tx_enable_bit_r <= RST_CTRL_BIT;
            nine_bit_select_r <= RST_CTRL_BIT;
            serial_port_enable_r <= RST_CTRL_BIT;
            tx_irq_enable_r <= RST_CTRL_BIT;
            baud_divisor_r <= RST_DIVISOR;
            tx_holding_buffer_r <= RST_HOLDING;
            tx_buffer_empty_flag_r <= RST_FLAG;
        end else begin
            ninth_data_bit_r <= ninth_data_bit_nxt;
            sync_select_r <= sync_select_nxt;
            tx_enable_bit_r <= tx_enable_bit_nxt;
            nine_bit_select_r <= nine_bit_select_nxt;
            serial_port_enable_r <= serial_port_enable_nxt;
            tx_irq_enable_r <= tx_irq_enable_nxt;
            baud_divisor_r <= baud_divisor_nxt;
            tx_holding_buffer_r <= tx_holding_buffer_nxt;
            tx_buffer_empty_flag_r <= tx_buffer_empty_flag_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB answer: captured at setup, so every access has no wait state
    always_comb begin
        pready_nxt = setup_ph;
        pslverr_nxt = setup_ph && !mapped;
        prdata_nxt = 32'h0000_0000;
        if (setup_ph && !pwrite_i) begin
            case (offset)
                // The shift register itself has no address [RULE11]
                OFS_TX_STATUS_CONTROL: begin
                    prdata_nxt[BIT_NINTH_DATA] = ninth_data_bit_r;
                    prdata_nxt[BIT_SHIFTER_EMPTY] = sif.empty; // [RULE10]
                    prdata_nxt[BIT_SYNC_SELECT] = sync_select_r;
                    prdata_nxt[BIT_TX_ENABLE] = tx_enable_bit_r;
                    prdata_nxt[BIT_NINE_SELECT] = nine_bit_select_r;
                end
                OFS_TX_HOLDING: prdata_nxt[7:0] = tx_holding_buffer_r;
                OFS_BAUD_DIVISOR: prdata_nxt[7:0] = baud_divisor_r;
                OFS_PERIPH_FLAG: prdata_nxt[BIT_BUFFER_EMPTY_FLAG] = tx_buffer_empty_flag_r;
                OFS_PERIPH_ENABLE: prdata_nxt[BIT_IRQ_ENABLE] = tx_irq_enable_r;
                OFS_PORT_CONTROL: prdata_nxt[BIT_PORT_ENABLE] = serial_port_enable_r;
                default: prdata_nxt = 32'h0000_0000;
            endcase
        end
        tx_oe_nxt = tx_run; // [RULE14]
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            tx_oe_r <= 1'b0;
        end else begin
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            tx_oe_r <= tx_oe_nxt;
        end
    end

    assign prdata_o = prdata_r;
    assign pready_o = pready_r;
    assign pslverr_o = pslverr_r;
    assign tx_oe_o = tx_oe_r;
    assign tx_o = sif.line;

    ////////////////////////////////////////////////////////////////////////////
    // Baud generator and shifter
    baud_tick_gen #(
        .DIV_W(DIVISOR_W),
        .MULT(BAUD_MULT)
    ) u_baud (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .clear_i(!tx_run), // [RULE17]
        .hold_i(sleep_i), // [RULE5]
        .divisor_i(baud_divisor_r),
        .cyc_en_o(cyc_en),
        .bit_tick_o(bit_tick)
    );

    assign sif.load = xfer;
    // Ninth bit taken at the move, hence software sets it before the data [RULE15]
    assign sif.data = {ninth_data_bit_r, tx_holding_buffer_r};
    assign sif.nine = nine_bit_select_r;
    assign sif.bit_tick = bit_tick;
    assign sif.abort = !tx_run; // [RULE14] [RULE17]
    assign sif.hold = sleep_i;

    frame_shifter u_shift (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .sif(sif)
    );

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    AST_FLAG_SET_ON_MOVE: assert property (xfer |=> tx_buffer_empty_flag_r && !sif.empty) // [RULE8]
        else $error("move did not set flag or fill shifter");
    AST_FLAG_CLEAR_ON_WRITE: assert property (wr_holding |=> !tx_buffer_empty_flag_r) // [RULE9]
        else $error("buffer write did not clear flag");
    AST_FLAG_STICKY: assert property (tx_buffer_empty_flag_r && !wr_holding |=> tx_buffer_empty_flag_r) // [RULE9]
        else $error("flag cleared without buffer write");
    AST_NO_EARLY_RELOAD: assert property (sif.load |-> sif.empty && $past(cyc_en, 4)) // [RULE7] [RULE19]
        else $error("shifter reloaded while busy");
    AST_ABORT_FLOATS: assert property (!tx_run |=> !tx_oe_o && tx_o && sif.empty) // [RULE14] [RULE17]
        else $error("disabled transmitter still drives");
    AST_SYNC_BLOCKS: assert property (sync_select_r |=> !tx_oe_o) // [RULE6]
        else $error("transmit active in synchronous mode");
    AST_IMMEDIATE_MOVE: assert property (wr_holding && tx_run && !sleep_i && sif.empty ##1
        (tx_run && !sleep_i && !wr_holding)[*4] |=> !sif.empty) // [RULE13]
        else $error("write to empty shifter not moved within an instruction cycle");
    AST_APB_ANSWER: assert property (psel_i && !penable_i |=> pready_o && (pslverr_o == !$past(mapped)))
        else $error("APB answer missing");

    COV_MOVE: cover property (xfer);
    COV_BACK_TO_BACK: cover property (xfer ##[1:300] wr_holding);
    COV_ABORT_MID_FRAME: cover property (!sif.empty && $fell(tx_run));

endmodule : async_serial_transmitter

// ### rtl/async_tx_pkg.sv
// Constants shared by the asynchronous serial transmitter and its helpers.
// Assumes a single 10 MHz clock and an APB register bus with 32-bit data.
//
// How it works
// (RULE1) Frames are NRZ: one start bit, eight or nine data bits, one stop bit.
// (RULE2) An 8-bit baud generator makes ticks at sixty-four times the bit rate.
// (RULE3) Transmitter runs on its own, sharing format and baud setting with a receiver.
// (RULE4) No hardware parity; software may put parity in the ninth bit.
// (RULE5) Sleep freezes the transmitter.
// (RULE6) Asynchronous mode only while the synchronous-select bit 4 is clear.
// (RULE7) The shifter reloads only after the previous stop bit has gone out.
// (RULE8) Buffer to shifter move takes one instruction cycle, empties buffer, sets flag bit 1.
// (RULE9) Flag sets regardless of its enable; only a buffer write clears it.
// (RULE10) Shifter-empty status bit 1 is read only and raises no interrupt.
// (RULE11) The shift register has no address and is invisible to software.
// (RULE12) Sending starts only with data buffered and a shift clock from the generator.
// (RULE13) A write with the shifter empty passes straight on, freeing the buffer.
// (RULE14) Clearing transmit enable aborts the frame and floats the pin.
// (RULE15) Software sets nine-bit select and ninth bit before writing the data.
// (RULE16) Software programs divisor, port enable, options, data, then transmit enable.
// (RULE17) Clearing port enable or transmit enable ends any frame and resets the logic.
// (RULE18) Software should write data before setting transmit enable for a sooner start.
// (RULE19) One instruction cycle is four clock phases.
// (RULE20) Line idles high, start low, data LSB first, stop high.
// (RULE21) Baud generator counts down and reloads; sixty-four ticks make one bit.

package async_tx_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_TX_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_TX_HOLDING = 8'h04;
    localparam logic [7:0] OFS_BAUD_DIVISOR = 8'h08;
    localparam logic [7:0] OFS_PERIPH_FLAG = 8'h0C;
    localparam logic [7:0] OFS_PERIPH_ENABLE = 8'h10;
    localparam logic [7:0] OFS_PORT_CONTROL = 8'h14;

    // Field positions
    localparam int BIT_NINTH_DATA = 0;
    localparam int BIT_SHIFTER_EMPTY = 1;
    localparam int BIT_SYNC_SELECT = 4;
    localparam int BIT_TX_ENABLE = 5;
    localparam int BIT_NINE_SELECT = 6;
    localparam int BIT_BUFFER_EMPTY_FLAG = 1;
    localparam int BIT_IRQ_ENABLE = 1;
    localparam int BIT_PORT_ENABLE = 0;

    // Reset values
    localparam logic RST_CTRL_BIT = 1'b0;
    localparam logic RST_FLAG = 1'b1;
    localparam logic [7:0] RST_DIVISOR = 8'h00;
    localparam logic [7:0] RST_HOLDING = 8'h00;

    // Timing counts
    localparam int INSTR_PHASES = 4;
    localparam int BAUD_MULT = 64;
    localparam int DIVISOR_W = 8;
    localparam int FRAME_DATA_MAX = 9;

endpackage : async_tx_pkg

// ### rtl/shift_if.sv
// Carrier between the transmitter control and its frame shifter.
// Assumes both ends share clk_i.
`timescale 1ns/100ps

interface shift_if;
    logic load;
    logic [8:0] data;
    logic nine;
    logic bit_tick;
    logic abort;
    logic hold;
    logic empty;
    logic line;

    modport ctrl (output load, data, nine, bit_tick, abort, hold, input empty, line);
    modport shifter (input load, data, nine, bit_tick, abort, hold, output empty, line);
endinterface : shift_if

// ### rtl/baud_tick_gen.sv
// Instruction-cycle divider and baud generator with x64 bit divider.
// Assumes divisor is stable while a frame runs.
`timescale 1ns/100ps

module baud_tick_gen
    import async_tx_pkg::*;
#(
    parameter int DIV_W = async_tx_pkg::DIVISOR_W,
    parameter int MULT = async_tx_pkg::BAUD_MULT
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Control
    input wire logic clear_i,
    input wire logic hold_i,
    input wire logic [DIV_W-1:0] divisor_i,
    // Enables
    output logic cyc_en_o,
    output logic bit_tick_o
);
    import async_tx_pkg::*;

    localparam int SUB_W = $clog2(MULT);
    localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(MULT - 1);
    localparam logic [1:0] PH_LAST = 2'(INSTR_PHASES - 1);

    if (DIV_W < 1 || MULT < 2 || (1 << SUB_W) != MULT) begin : g_chk
        $error("baud_tick_gen: unsupported parameters");
    end

    logic [1:0] phase_r, phase_nxt;
    logic [DIV_W-1:0] cnt_r, cnt_nxt;
    logic [SUB_W-1:0] sub_r, sub_nxt;
    logic baud_tick;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        phase_nxt = phase_r + 2'd1; // [RULE19]
        baud_tick = !clear_i && !hold_i && (cnt_r == '0);
        cnt_nxt = cnt_r;
        sub_nxt = sub_r;
        if (clear_i) begin
            cnt_nxt = divisor_i;
            sub_nxt = '0;
        end else if (!hold_i) begin
            // Shared divisor setting; the receiver would tap the same ticks [RULE3]
            cnt_nxt = baud_tick ? divisor_i : cnt_r - 1'b1; // [RULE2] [RULE21]
            if (baud_tick) begin
                sub_nxt = sub_r + 1'b1; // [RULE21]
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            phase_r <= 2'd0;
            cnt_r <= '0;
            sub_r <= '0;
        end else begin
            phase_r <= phase_nxt;
            cnt_r <= cnt_nxt;
            sub_r <= sub_nxt;
        end
    end

    assign cyc_en_o = (phase_r == PH_LAST);
    assign bit_tick_o = baud_tick && (sub_r == SUB_LAST);

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    AST_INSTR_FOUR_PHASES: assert property (cyc_en_o |=> !cyc_en_o ##1 !cyc_en_o ##1 !cyc_en_o ##1 cyc_en_o) // [RULE19]
        else $error("instruction cycle is not four clocks");
    AST_BIT_NEEDS_BAUD: assert property (bit_tick_o |-> cnt_r == '0 ##1 sub_r == '0) // [RULE21]
        else $error("bit tick without 64th baud tick");

endmodule : baud_tick_gen

// ### rtl/frame_shifter.sv
// Hidden shift register sending start, data and stop bits on bit ticks.
// Assumes load only arrives while empty.
`timescale 1ns/100ps

module frame_shifter
    import async_tx_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Control side
    shift_if.shifter sif
);
    import async_tx_pkg::*;

    typedef enum logic [2:0] {
        S_EMPTY = 3'b000,
        S_READY = 3'b001,
        S_START = 3'b010,
        S_DATA = 3'b011,
        S_STOP = 3'b100
    } shift_state_e;

    shift_state_e state_r, state_nxt;
    logic [8:0] sr_r, sr_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic nine_r, nine_nxt;
    logic line_r, line_nxt;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_nxt = state_r;
        sr_nxt = sr_r;
        cnt_nxt = cnt_r;
        nine_nxt = nine_r;
        line_nxt = line_r;
        if (sif.abort) begin
            state_nxt = S_EMPTY; // [RULE14] [RULE17]
            line_nxt = 1'b1;
        end else if (!sif.hold) begin // [RULE5]
            case (state_r)
                S_EMPTY: begin
                    line_nxt = 1'b1; // [RULE20]
                    if (sif.load) begin
                        sr_nxt = sif.data;
                        nine_nxt = sif.nine;
                        state_nxt = S_READY;
                    end
                end
                S_READY: begin
                    if (sif.bit_tick) begin
                        line_nxt = 1'b0; // [RULE12] [RULE20]
                        state_nxt = S_START;
                    end
                end
                S_START: begin
                    if (sif.bit_tick) begin
                        line_nxt = sr_r[0]; // [RULE20]
                        sr_nxt = {1'b0, sr_r[8:1]};
                        cnt_nxt = 4'd0;
                        state_nxt = S_DATA;
                    end
                end
                S_DATA: begin
                    if (sif.bit_tick) begin
                        // Ninth bit is sent as given; no parity is made here [RULE4]
                        if (cnt_r == (nine_r ? 4'd8 : 4'd7)) begin // [RULE1]
                            line_nxt = 1'b1;
                            state_nxt = S_STOP;
                        end else begin
                            line_nxt = sr_r[0];
                            sr_nxt = {1'b0, sr_r[8:1]};
                            cnt_nxt = cnt_r + 4'd1;
                        end
                    end
                end
                S_STOP: begin
                    if (sif.bit_tick) begin
                        state_nxt = S_EMPTY; // [RULE7]
                    end
                end
                default: begin
                    state_nxt = S_EMPTY;
                    line_nxt = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= S_EMPTY;
            sr_r <= '0;
            cnt_r <= 4'd0;
            nine_r <= 1'b0;
            line_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            sr_r <= sr_nxt;
            cnt_r <= cnt_nxt;
            nine_r <= nine_nxt;
            line_r <= line_nxt;
        end
    end

    assign sif.empty = (state_r == S_EMPTY);
    assign sif.line = line_r;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    AST_START_ON_TICK: assert property ($fell(line_r) && $past(state_r) == S_READY |-> $past(sif.bit_tick)) // [RULE12]
        else $error("start bit began without a shift clock");
    AST_SLEEP_FREEZE: assert property (sif.hold && !sif.abort |=> $stable(line_r) && $stable(state_r)) // [RULE5]
        else $error("shifter moved during sleep");
    AST_STOP_HIGH: assert property (state_r == S_STOP |-> line_r) // [RULE1] [RULE20]
        else $error("stop bit not high");
    COV_NINE_BIT: cover property (state_r == S_DATA && nine_r && cnt_r == 4'd8);

endmodule : frame_shifter

// ### sim/line_receiver.sv
// Remote line receiver model: samples the serial line mid-bit.
// Assumes one bit lasts BIT_CLKS clocks and the line idles high.
`timescale 1ns/100ps

module line_receiver #(
    parameter int BIT_CLKS = 64
) (
    // Clock and line
    input wire logic clk_i,
    input wire logic line_i,
    input wire logic oe_i,
    input wire logic nine_i,
    // Result
    output logic got_o,
    output logic [8:0] word_o,
    output logic stop_o
);
    logic ok;
    int n;
    initial begin
        got_o = 1'b0;
        word_o = '0;
        stop_o = 1'b0;
        forever begin
            @(negedge line_i);
            n = nine_i ? 9 : 8;
            ok = 1'b1;
            word_o = '0;
            repeat (BIT_CLKS / 2) @(posedge clk_i);
            for (int i = 0; i <= n; i++) begin
                repeat (BIT_CLKS) @(posedge clk_i);
                ok &= oe_i;
                if (i < n) word_o[i] = line_i;
                else stop_o = line_i;
            end
            // Aborted frames are dropped, never reported
            got_o = ok;
            @(posedge clk_i);
            got_o = 1'b0;
        end
    end
endmodule : line_receiver

// ### sim/async_serial_transmitter_test.sv
// Self-checking bench for the serial transmitter over APB.
// Assumes divisor 0, so one bit is BAUD_MULT clocks.
`timescale 1ns/100ps

module async_serial_transmitter_test;
    import async_tx_pkg::*;
    localparam logic [31:0] TX_ENABLE_BIT = 32'h0000_0001 << BIT_TX_ENABLE;
    localparam logic [31:0] EMPTY = 32'h0000_0001 << BIT_SHIFTER_EMPTY;
    localparam logic [31:0] FLAG = 32'h0000_0001 << BIT_BUFFER_EMPTY_FLAG;
    localparam logic [31:0] NINE = 32'h0000_0001 << BIT_NINE_SELECT;
    localparam logic [31:0] SYNC = 32'h0000_0001 << BIT_SYNC_SELECT;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic sleep = 1'b0;
    logic nine = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic tx;
    logic tx_oe;
    logic got;
    logic [8:0] word;
    logic stop;
    logic [31:0] rd;
    logic er;
    logic [7:0] b;
    logic [8:0] exq[$];
    int err_total = 0;
    int cmp_count = 0;
    int seed = 32'h46ac;

    always #50 clk_i = ~clk_i;

    async_serial_transmitter u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .sleep_i(sleep), .tx_o(tx), .tx_oe_o(tx_oe));
    line_receiver #(.BIT_CLKS(BAUD_MULT)) u_rx (.clk_i(clk_i), .line_i(tx), .oe_i(tx_oe), .nine_i(nine),
        .got_o(got), .word_o(word), .stop_o(stop));

    ////////////////////////////////////////////////////////////////
    task stop_test;
        $display("errors %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s exp %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Entered right after a rising edge; leaves one idle cycle
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_total++;
            stop_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
    endtask : apb

    task rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(name, rd, exp);
    endtask : rdc

    task wait_idle;
        int k;
        k = 0;
        while (exq.size() != 0 && k < 3000) begin
            @(posedge clk_i);
            k++;
        end
        if (exq.size() != 0) begin
            err_total++;
            stop_test();
        end
        repeat (BAUD_MULT) @(posedge clk_i);
    endtask : wait_idle

    // Frame checker: oldest expected word against each received one
    always @(negedge clk_i) begin
        if (got === 1'b1) begin
            if (exq.size() == 0) chk("rx_extra", 1, 0);
            else chk("rx_word", word, exq.pop_front());
            chk("rx_stop", stop, 1);
        end
    end

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        rdc("status_rst", OFS_TX_STATUS_CONTROL, EMPTY);
        chk("err_ok", er, 0);
        rdc("flag_rst", OFS_PERIPH_FLAG, FLAG);
        apb(1'b0, 8'h18, 32'h0000_0000);
        chk("unmapped", er, 1);
        apb(1'b1, OFS_BAUD_DIVISOR, 32'h0000_0000);
        apb(1'b1, OFS_PORT_CONTROL, 32'h0000_0001);
        b = $random(seed);
        exq.push_back({1'b0, b});
        apb(1'b1, OFS_TX_HOLDING, {24'h0, b});
        rdc("flag_full", OFS_PERIPH_FLAG, 0);
        apb(1'b1, OFS_TX_STATUS_CONTROL, TX_ENABLE_BIT);
        // Move waits for the next instruction cycle
        repeat (INSTR_PHASES) @(posedge clk_i);
        rdc("moved", OFS_TX_STATUS_CONTROL, TX_ENABLE_BIT);
        b = $random(seed);
        exq.push_back({1'b0, b});
        apb(1'b1, OFS_TX_HOLDING, {24'h0, b});
        rdc("flag_wait", OFS_PERIPH_FLAG, 0);
        wait_idle();
        rdc("flag_done", OFS_PERIPH_FLAG, FLAG);
        rdc("status_idle", OFS_TX_STATUS_CONTROL, TX_ENABLE_BIT | EMPTY);
        apb(1'b1, OFS_PERIPH_FLAG, 32'h0000_0000);
        rdc("flag_ro", OFS_PERIPH_FLAG, FLAG);
        nine = 1'b1;
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, OFS_TX_STATUS_CONTROL, TX_ENABLE_BIT | NINE | 32'(k));
            b = $random(seed);
            exq.push_back({k[0], b});
            apb(1'b1, OFS_TX_HOLDING, {24'h0, b});
            wait_idle();
        end
        nine = 1'b0;
        apb(1'b1, OFS_TX_STATUS_CONTROL, TX_ENABLE_BIT);
        sleep <= 1'b1;
        b = $random(seed);
        exq.push_back({1'b0, b});
        apb(1'b1, OFS_TX_HOLDING, {24'h0, b});
        repeat (20) @(posedge clk_i);
        rdc("flag_sleep", OFS_PERIPH_FLAG, 0);
        sleep <= 1'b0;
        wait_idle();
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, OFS_PORT_CONTROL, 32'h0000_0001);
            apb(1'b1, OFS_TX_STATUS_CONTROL, TX_ENABLE_BIT);
            apb(1'b1, OFS_TX_HOLDING, $random(seed));
            repeat (200) @(posedge clk_i);
            chk("oe_run", tx_oe, 1);
            apb(1'b1, k ? OFS_PORT_CONTROL : OFS_TX_STATUS_CONTROL, 32'h0000_0000);
            // Pin flops settle one clock after the write
            @(posedge clk_i);
            chk("oe_abort", tx_oe, 0);
            chk("tx_abort", tx, 1);
            rdc("empty_abort", OFS_TX_STATUS_CONTROL, k ? TX_ENABLE_BIT | EMPTY : EMPTY);
            repeat (700) @(posedge clk_i);
        end
        apb(1'b1, OFS_PORT_CONTROL, 32'h0000_0001);
        apb(1'b1, OFS_TX_STATUS_CONTROL, TX_ENABLE_BIT | SYNC);
        repeat (4) @(posedge clk_i);
        chk("oe_sync", tx_oe, 0);
        stop_test();
    end
endmodule : async_serial_transmitter_test
